// ---- iprot_pkg.sv ----
// iprot_pkg: command codes, field layouts, reset values and types for input protection.
// assumes: every importer runs on one clock; voltages compare in 0.25 V units.
// Behaviour
// - turn-on threshold has fixed exponent -2; mantissa writable, loaded from NVM at reset.
// - conversion may not begin before measured input reaches the turn-on threshold.
// - every input-protection command is one copy shared by both channels, page ignored.
// - fault limit commands use word transactions only; byte access is refused.
// - overvoltage fault when measured input exceeds the overvoltage limit.
// - overvoltage limit exponent fixed zero; mantissa from NVM, only 0 to 31 valid.
// - response commands answer byte reads with their byte; writes never change them.
// - overvoltage response reads 00h; fault flags and alerts but conversion continues.
// - overvoltage fault sets other, input-word and overvoltage input status bits.
// - overvoltage or undervoltage fault asserts alert pin unless its mask bit set.
// - undervoltage fault masked until input first exceeded turn-on and unit enabled.
// - undervoltage limit fully writable, NVM loaded; only listed codes are valid.
// - undervoltage fault sets other, input-word and undervoltage input status bits.
// - undervoltage response reads C0h; shut down, restart once condition clears.
// - input current limit holds threshold; bits 15:11 read-only, 10:0 writable.
// - input current exponent fixed -1; accepted mantissa 0 to 127.
// - on reset or restore, current limit keeps stored 8 A multiples or 63.5 A, else 63.5 A.
package iprot_pkg;
  localparam logic [7:0]  CODE_TURN_ON        = 8'h35;
  localparam logic [7:0]  CODE_OV_LIMIT       = 8'h55;
  localparam logic [7:0]  CODE_OV_RESPONSE    = 8'h56;
  localparam logic [7:0]  CODE_UV_LIMIT       = 8'h59;
  localparam logic [7:0]  CODE_UV_RESPONSE    = 8'h5A;
  localparam logic [7:0]  CODE_IIN_LIMIT      = 8'h5B;
  localparam int          EXP_MSB             = 15;
  localparam int          EXP_LSB             = 11;
  localparam int          MAN_MSB             = 10;
  localparam logic [4:0]  TURN_ON_EXP         = 5'h1E;
  localparam logic [4:0]  OV_EXP              = 5'h00;
  localparam logic [4:0]  IIN_EXP             = 5'h1F;
  localparam logic [10:0] OV_MAN_MAX          = 11'h01F;
  localparam logic [10:0] IIN_MAN_MAX         = 11'h07F;
  localparam logic [7:0]  OV_RESPONSE         = 8'h00;
  localparam logic [7:0]  UV_RESPONSE         = 8'hC0;
  localparam logic [15:0] UV_CODE_LOW         = 16'hF011;
  localparam logic [7:0]  UV_CODE_HI_BYTE     = 8'hF8;
  localparam logic [7:0]  UV_CODE_MIN_LO      = 8'h0B;
  localparam logic [7:0]  UV_CODE_MAX_LO      = 8'h17;
  localparam logic [15:0] IIN_CODE_FULL       = 16'hF87F;
  localparam logic [7:0]  IIN_CODE_HI_BYTE    = 8'hF8;
  localparam logic [3:0]  IIN_STEP_MIN        = 4'h1;
  localparam logic [3:0]  IIN_STEP_MAX        = 4'h7;
  localparam logic [5:0]  QUARTER_EXP_OFFSET  = 6'h02;

  typedef enum logic [1:0] {
    IPROT_OFF      = 2'b00,
    IPROT_WAIT_VIN = 2'b01,
    IPROT_RUN      = 2'b11,
    IPROT_UV_STOP  = 2'b10
  } iprot_state_t;

  typedef struct packed {
    logic         en_sync1;
    logic         en_sync2;
    iprot_state_t state;
    logic         seen_above_on;
    logic         seen_enabled;
    logic         ov_cond;
    logic         uv_cond;
    logic         conv_en;
  } iprot_detect_t;

  typedef struct packed {
    logic other;
    logic input_word;
    logic ov;
    logic uv;
    logic alert_oe;
  } iprot_status_t;

  typedef struct packed {
    logic [10:0] turn_on_mantissa;
    logic [10:0] overvolt_limit_mantissa;
    logic [15:0] undervolt_limit;
    logic [10:0] input_current_limit_mantissa;
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } iprot_regs_t;

  localparam iprot_detect_t DETECT_RESET = '{state: IPROT_OFF, default: 1'b0};
  localparam iprot_status_t STATUS_RESET = '0;

  // linear code to 0.25 V units; exponents above +3 would overflow and are not used here
  function automatic logic [15:0] lin_to_quarter(input logic [15:0] code);
    logic [5:0]  sh;
    logic [5:0]  amt;
    logic [26:0] wide;
    sh   = {code[EXP_MSB], code[EXP_MSB:EXP_LSB]} + QUARTER_EXP_OFFSET;
    amt  = sh[5] ? 6'(-sh) : sh;
    wide = {16'h0000, code[MAN_MSB:0]};
    wide = sh[5] ? (wide >> amt) : (wide << amt);
    return wide[15:0];
  endfunction
endpackage

// ---- iprot_fault_if.sv ----
// iprot_fault_if: fault conditions from the detector to the status block.
// assumes: both ends on the same clock; conditions are registered levels.
`timescale 1ns/1ps
interface iprot_fault_if;
  logic ov_cond;
  logic uv_cond;
  modport detector (output ov_cond, output uv_cond);
  modport status   (input ov_cond, input uv_cond);
endinterface

// ---- iprot_detect.sv ----
// iprot_detect: threshold compares, undervoltage arming and conversion sequencing.
// assumes: thresholds and measured input in 0.25 V units, same clock; enable is a pin.
`timescale 1ns/1ps
module iprot_detect
  import iprot_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_clock_en,
  input  wire logic        i_unit_enable,
  input  wire logic [15:0] i_vin_quarter,
  input  wire logic [15:0] i_turn_on_quarter,
  input  wire logic [15:0] i_overvolt_quarter,
  input  wire logic [15:0] i_undervolt_quarter,
  output logic             o_conversion_enable,
  iprot_fault_if.detector  flt
);
  import iprot_pkg::*;

  iprot_detect_t s;
  iprot_detect_t next_s;
  logic          en;
  logic          armed;

  always_comb begin
    next_s          = s;
    next_s.en_sync1 = i_unit_enable;
    next_s.en_sync2 = s.en_sync1;
    en              = s.en_sync2;
    armed           = s.seen_above_on & s.seen_enabled;
    if (i_vin_quarter > i_turn_on_quarter) begin
      next_s.seen_above_on = 1'b1;
    end
    if (en) begin
      next_s.seen_enabled = 1'b1;
    end
    next_s.ov_cond = i_vin_quarter > i_overvolt_quarter;
    next_s.uv_cond = armed & (i_vin_quarter < i_undervolt_quarter);
    case (s.state)
      IPROT_OFF: begin
        if (en) begin
          next_s.state = IPROT_WAIT_VIN;
        end
      end
      IPROT_WAIT_VIN: begin
        if (!en) begin
          next_s.state = IPROT_OFF;
        end else if (i_vin_quarter >= i_turn_on_quarter) begin
          next_s.state = IPROT_RUN;
        end
      end
      IPROT_RUN: begin
        // overvoltage deliberately has no effect here
        if (!en) begin
          next_s.state = IPROT_OFF;
        end else if (s.uv_cond) begin
          next_s.state = IPROT_UV_STOP;
        end
      end
      default: begin
        if (!en) begin
          next_s.state = IPROT_OFF;
        end else if (!s.uv_cond) begin
          next_s.state = IPROT_RUN;
        end
      end
    endcase
    next_s.conv_en = (next_s.state == IPROT_RUN);
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      s <= DETECT_RESET;
    end else if (i_clock_en) begin
      s <= next_s;
    end
  end

  assign o_conversion_enable = s.conv_en;
  assign flt.ov_cond         = s.ov_cond;
  assign flt.uv_cond         = s.uv_cond;
endmodule

// ---- iprot_status.sv ----
// iprot_status: sticky fault status bits and the open-drain alert drive.
// assumes: clear is a one-cycle pulse on the same clock; mask bits are static levels.
`timescale 1ns/1ps
module iprot_status
  import iprot_pkg::*;
(
  input  wire logic       i_clock,
  input  wire logic       i_srst,
  input  wire logic       i_clock_en,
  input  wire logic       i_clear_faults,
  input  wire logic       i_mask_overvolt,
  input  wire logic       i_mask_undervolt,
  iprot_fault_if.status   flt,
  output logic            o_other,
  output logic            o_input_word,
  output logic            o_overvolt,
  output logic            o_undervolt,
  output logic            o_alert_oe
);
  import iprot_pkg::*;

  iprot_status_t s;
  iprot_status_t next_s;
  logic          any_fault;

  always_comb begin
    // a fault present in the clear cycle stays set
    any_fault         = flt.ov_cond | flt.uv_cond;
    next_s            = s;
    next_s.ov         = flt.ov_cond | (s.ov & ~i_clear_faults);
    next_s.uv         = flt.uv_cond | (s.uv & ~i_clear_faults);
    next_s.other      = any_fault | (s.other & ~i_clear_faults);
    next_s.input_word = any_fault | (s.input_word & ~i_clear_faults);
    next_s.alert_oe   = (next_s.ov & ~i_mask_overvolt) | (next_s.uv & ~i_mask_undervolt);
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      s <= STATUS_RESET;
    end else if (i_clock_en) begin
      s <= next_s;
    end
  end

  assign o_other      = s.other;
  assign o_input_word = s.input_word;
  assign o_overvolt   = s.ov;
  assign o_undervolt  = s.uv;
  assign o_alert_oe   = s.alert_oe;
endmodule

// ---- iprot_top.sv ----
// iprot_top: shared input-protection command registers and their fault logic.
// assumes: a PMBus front end hands over decoded commands on this clock;
// measured input arrives from the ADC path in 0.25 V units on the same clock.
`timescale 1ns/1ps
module iprot_top
  import iprot_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_clock_en,
  input  wire logic        i_cmd_valid,
  input  wire logic        i_cmd_write,
  input  wire logic        i_cmd_word,
  input  wire logic [7:0]  i_cmd_code,
  input  wire logic [15:0] i_cmd_wdata,
  input  wire logic        i_clear_faults,
  input  wire logic        i_restore_defaults,
  input  wire logic [15:0] i_nvm_turn_on,
  input  wire logic [15:0] i_nvm_overvolt_limit,
  input  wire logic [15:0] i_nvm_undervolt_limit,
  input  wire logic [15:0] i_nvm_input_current_limit,
  input  wire logic [15:0] i_vin_quarter,
  input  wire logic        i_unit_enable,
  input  wire logic        i_alert_mask_overvolt,
  input  wire logic        i_alert_mask_undervolt,
  output logic             o_cmd_ack,
  output logic             o_cmd_error,
  output logic [15:0]      o_cmd_rdata,
  output logic             o_conversion_enable,
  output logic             o_status_byte_other,
  output logic             o_status_word_input,
  output logic             o_status_input_overvolt,
  output logic             o_status_input_undervolt,
  output logic             o_host_alert_pin_o,
  output logic             o_host_alert_pin_oe,
  output logic [15:0]      o_input_current_limit
);
  import iprot_pkg::*;

  iprot_regs_t   s;
  iprot_regs_t   next_s;
  iprot_fault_if flt ();

  logic [15:0] turn_on_word;
  logic [15:0] overvolt_word;
  logic [15:0] current_word;
  logic [15:0] turn_on_quarter;
  logic [15:0] overvolt_quarter;
  logic [15:0] undervolt_quarter;
  logic        is_word_cmd;
  logic        is_byte_cmd;
  logic        take;

  // only the listed undervoltage codes are accepted
  function automatic logic uv_code_ok(input logic [15:0] code);
    logic [7:0] lo;
    lo = code[7:0];
    return (code == UV_CODE_LOW) ||
           ((code[15:8] == UV_CODE_HI_BYTE) && lo[0] &&
            (lo >= UV_CODE_MIN_LO) && (lo <= UV_CODE_MAX_LO));
  endfunction

  // limited NVM backup: only 8 A steps and full scale survive a reload
  function automatic logic [10:0] iin_restore(input logic [15:0] code);
    logic keep;
    keep = (code == IIN_CODE_FULL) ||
           ((code[15:8] == IIN_CODE_HI_BYTE) && (code[3:0] == 4'h0) &&
            (code[7:4] >= IIN_STEP_MIN) && (code[7:4] <= IIN_STEP_MAX));
    return keep ? code[MAN_MSB:0] : IIN_CODE_FULL[MAN_MSB:0];
  endfunction

  always_comb begin
    turn_on_word  = {TURN_ON_EXP, s.turn_on_mantissa};
    overvolt_word = {OV_EXP, s.overvolt_limit_mantissa};
    current_word  = {IIN_EXP, s.input_current_limit_mantissa};
  end

  always_comb begin
    is_word_cmd = (i_cmd_code == CODE_TURN_ON) || (i_cmd_code == CODE_OV_LIMIT) ||
                  (i_cmd_code == CODE_UV_LIMIT) || (i_cmd_code == CODE_IIN_LIMIT);
    is_byte_cmd = (i_cmd_code == CODE_OV_RESPONSE) || (i_cmd_code == CODE_UV_RESPONSE);
    take        = i_cmd_valid;
  end

  always_comb begin
    next_s       = s;
    next_s.ack   = 1'b0;
    next_s.err   = 1'b0;
    if (i_srst || i_restore_defaults) begin
      // reload from NVM; fixed exponents are never stored
      next_s.turn_on_mantissa             = i_nvm_turn_on[MAN_MSB:0];
      next_s.overvolt_limit_mantissa      = i_nvm_overvolt_limit[MAN_MSB:0];
      next_s.undervolt_limit              = i_nvm_undervolt_limit;
      next_s.input_current_limit_mantissa = iin_restore(i_nvm_input_current_limit);
      next_s.rdata                        = 16'h0000;
    end else if (take) begin
      // one shared copy: no page select reaches this block
      next_s.ack   = 1'b1;
      next_s.rdata = 16'h0000;
      if (is_word_cmd && !i_cmd_word) begin
        next_s.err = 1'b1;
      end else if (is_byte_cmd && i_cmd_word) begin
        next_s.err = 1'b1;
      end else if (i_cmd_code == CODE_TURN_ON) begin
        if (i_cmd_write) begin
          next_s.turn_on_mantissa = i_cmd_wdata[MAN_MSB:0];
        end else begin
          next_s.rdata = turn_on_word;
        end
      end else if (i_cmd_code == CODE_OV_LIMIT) begin
        if (i_cmd_write) begin
          if (i_cmd_wdata[MAN_MSB:0] <= OV_MAN_MAX) begin
            next_s.overvolt_limit_mantissa = i_cmd_wdata[MAN_MSB:0];
          end else begin
            next_s.err = 1'b1;
          end
        end else begin
          next_s.rdata = overvolt_word;
        end
      end else if (i_cmd_code == CODE_OV_RESPONSE) begin
        if (!i_cmd_write) begin
          next_s.rdata = {8'h00, OV_RESPONSE};
        end
      end else if (i_cmd_code == CODE_UV_LIMIT) begin
        if (i_cmd_write) begin
          if (uv_code_ok(i_cmd_wdata)) begin
            next_s.undervolt_limit = i_cmd_wdata;
          end else begin
            next_s.err = 1'b1;
          end
        end else begin
          next_s.rdata = s.undervolt_limit;
        end
      end else if (i_cmd_code == CODE_UV_RESPONSE) begin
        if (!i_cmd_write) begin
          next_s.rdata = {8'h00, UV_RESPONSE};
        end
      end else if (i_cmd_code == CODE_IIN_LIMIT) begin
        if (i_cmd_write) begin
          if (i_cmd_wdata[MAN_MSB:0] <= IIN_MAN_MAX) begin
            next_s.input_current_limit_mantissa = i_cmd_wdata[MAN_MSB:0];
          end else begin
            next_s.err = 1'b1;
          end
        end else begin
          next_s.rdata = current_word;
        end
      end else begin
        next_s.err = 1'b1;
      end
    end
  end

  // reset is honoured even with the clock enable low
  always_ff @(posedge i_clock) begin
    if (i_srst || i_clock_en) begin
      s <= next_s;
    end
  end

  always_comb begin
    turn_on_quarter   = lin_to_quarter(turn_on_word);
    overvolt_quarter  = lin_to_quarter(overvolt_word);
    undervolt_quarter = lin_to_quarter(s.undervolt_limit);
  end

  iprot_detect u_detect (
    .i_clock             (i_clock),
    .i_srst              (i_srst),
    .i_clock_en          (i_clock_en),
    .i_unit_enable       (i_unit_enable),
    .i_vin_quarter       (i_vin_quarter),
    .i_turn_on_quarter   (turn_on_quarter),
    .i_overvolt_quarter  (overvolt_quarter),
    .i_undervolt_quarter (undervolt_quarter),
    .o_conversion_enable (o_conversion_enable),
    .flt                 (flt.detector)
  );

  iprot_status u_status (
    .i_clock          (i_clock),
    .i_srst           (i_srst),
    .i_clock_en       (i_clock_en),
    .i_clear_faults   (i_clear_faults),
    .i_mask_overvolt  (i_alert_mask_overvolt),
    .i_mask_undervolt (i_alert_mask_undervolt),
    .flt              (flt.status),
    .o_other          (o_status_byte_other),
    .o_input_word     (o_status_word_input),
    .o_overvolt       (o_status_input_overvolt),
    .o_undervolt      (o_status_input_undervolt),
    .o_alert_oe       (o_host_alert_pin_oe)
  );

  // open drain: the pin is only ever pulled low
  assign o_host_alert_pin_o    = 1'b0;
  assign o_cmd_ack             = s.ack;
  assign o_cmd_error           = s.err;
  assign o_cmd_rdata           = s.rdata;
  assign o_input_current_limit = current_word;
endmodule

// ---- iprot_top_asserts.sv ----
// iprot_top_asserts: timing and value checks on the top's command and fault ports.
// assumes: bound into iprot_top; one clock domain with synchronous reset.
`timescale 1ns/1ps
module iprot_top_asserts (
  input wire logic        i_clock,
  input wire logic        i_srst,
  input wire logic        i_clock_en,
  input wire logic        i_cmd_valid,
  input wire logic        i_cmd_write,
  input wire logic        i_cmd_word,
  input wire logic [7:0]  i_cmd_code,
  input wire logic        i_clear_faults,
  input wire logic        i_restore_defaults,
  input wire logic        i_alert_mask_overvolt,
  input wire logic        i_alert_mask_undervolt,
  input wire logic        o_cmd_ack,
  input wire logic        o_cmd_error,
  input wire logic [15:0] o_cmd_rdata,
  input wire logic        o_status_byte_other,
  input wire logic        o_status_word_input,
  input wire logic        o_status_input_overvolt,
  input wire logic        o_status_input_undervolt,
  input wire logic        o_host_alert_pin_o,
  input wire logic        o_host_alert_pin_oe,
  input wire logic [15:0] o_input_current_limit
);
  logic taken;
  logic word_cmd;
  assign taken    = i_cmd_valid && i_clock_en && !i_srst && !i_restore_defaults;
  assign word_cmd = i_cmd_code inside {8'h35, 8'h55, 8'h59, 8'h5B};
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_srst);
  sequence s_byte_read(code);
    taken && !i_cmd_write && !i_cmd_word && i_cmd_code == code;
  endsequence
  sequence s_clean_ack;
    o_cmd_ack && !o_cmd_error;
  endsequence
  // frozen cycles hold the last answer, so only edges that ran are checked
  answer_once_a: assert property ($past(i_clock_en) |-> o_cmd_ack == $past(taken))
    else $error("answer not one cycle after request");
  byte_refused_a: assert property (taken && !i_cmd_word && word_cmd |=> o_cmd_ack && o_cmd_error)
    else $error("byte access to limit not refused");
  ov_response_a: assert property (s_byte_read(8'h56) ##1 s_clean_ack |-> o_cmd_rdata == 16'h0000)
    else $error("overvoltage response not 00");
  uv_response_a: assert property (s_byte_read(8'h5A) ##1 s_clean_ack |-> o_cmd_rdata == 16'h00C0)
    else $error("undervoltage response not C0");
  refused_data_a: assert property (o_cmd_ack && o_cmd_error |-> o_cmd_rdata == 16'h0000)
    else $error("refused answer carries data");
  current_exp_a: assert property (o_input_current_limit[15:11] == 5'h1F)
    else $error("current limit exponent not fixed");
  ov_flags_a: assert property ($rose(o_status_input_overvolt) |-> o_status_byte_other && o_status_word_input)
    else $error("overvoltage without summary bits");
  uv_flags_a: assert property ($rose(o_status_input_undervolt) |-> o_status_byte_other && o_status_word_input)
    else $error("undervoltage without summary bits");
  alert_unmasked_a: assert property (o_status_input_overvolt && !i_alert_mask_overvolt
    && $stable(i_alert_mask_overvolt) |-> o_host_alert_pin_oe) else $error("unmasked fault without alert");
  alert_masked_a: assert property (i_alert_mask_overvolt && i_alert_mask_undervolt
    && $stable(i_alert_mask_overvolt) && $stable(i_alert_mask_undervolt) |-> !o_host_alert_pin_oe)
    else $error("alert while masked");
  uv_alert_a: assert property (o_status_input_undervolt && !i_alert_mask_undervolt
    && $stable(i_alert_mask_undervolt) |-> o_host_alert_pin_oe && !o_host_alert_pin_o)
    else $error("unmasked undervoltage without alert");
  status_sticky_a: assert property (o_status_input_overvolt && !i_clear_faults && !i_restore_defaults
    |=> o_status_input_overvolt) else $error("fault bit dropped without clear");
endmodule
bind iprot_top iprot_top_asserts iprot_top_asserts_i (.i_clock(i_clock), .i_srst(i_srst),
  .i_clock_en(i_clock_en), .i_cmd_valid(i_cmd_valid), .i_cmd_write(i_cmd_write), .i_cmd_word(i_cmd_word),
  .i_cmd_code(i_cmd_code), .i_clear_faults(i_clear_faults), .i_restore_defaults(i_restore_defaults),
  .i_alert_mask_overvolt(i_alert_mask_overvolt), .i_alert_mask_undervolt(i_alert_mask_undervolt),
  .o_cmd_ack(o_cmd_ack), .o_cmd_error(o_cmd_error), .o_cmd_rdata(o_cmd_rdata),
  .o_status_byte_other(o_status_byte_other), .o_status_word_input(o_status_word_input),
  .o_status_input_overvolt(o_status_input_overvolt), .o_status_input_undervolt(o_status_input_undervolt),
  .o_host_alert_pin_o(o_host_alert_pin_o), .o_host_alert_pin_oe(o_host_alert_pin_oe),
  .o_input_current_limit(o_input_current_limit));

// ---- iprot_host_model.sv ----
// iprot_host_model: host side of the command port, one request per xfer call.
// assumes: called from one bench process; same clock as the design.
`timescale 1ns/1ps
module iprot_host_model (
  input  wire logic        i_clock,
  output logic             o_valid,
  output logic             o_write,
  output logic             o_word,
  output logic [7:0]       o_code,
  output logic [15:0]      o_wdata
);
  initial begin
    o_valid = 1'h0;
    o_write = 1'h0;
    o_word  = 1'h0;
    o_code  = 8'h00;
    o_wdata = 16'h0000;
  end
  // back to back calls give a request every cycle
  task automatic xfer(input logic wr, input logic wd, input logic [7:0] code, input logic [15:0] data);
    @(posedge i_clock);
    o_valid <= 1'h1;
    o_write <= wr;
    o_word  <= wd;
    o_code  <= code;
    o_wdata <= data;
  endtask
  // released code and data show the inverse so a stale value never passes
  task automatic idle();
    @(posedge i_clock);
    o_valid <= 1'h0;
    o_code  <= ~o_code;
    o_wdata <= ~o_wdata;
  endtask
endmodule

// ---- iprot_tb.sv ----
// testbench: drives the input-protection top through the host model, checks answers and fault levels.
// assumes: package, interface, design, checker and host model compiled first.
`timescale 1ns/1ps
module testbench;
  import iprot_pkg::*;
  logic        i_clock, i_srst, clock_en, clear, restore, unit_en, mask_ov, mask_uv;
  logic        cmd_valid, cmd_write, cmd_word, ack, err, conv, other, in_word, ov, uv, alert_oe;
  logic [7:0]  cmd_code, lfsr;
  logic [15:0] cmd_wdata, nvm_on, nvm_ov, nvm_uv, nvm_iin, vin, rdata, iin_lim;
  logic [16:0] exp_q[$];
  int          n_errors, tests_run, cycles;
  iprot_host_model iprot_host_model_i (.i_clock(i_clock), .o_valid(cmd_valid), .o_write(cmd_write),
    .o_word(cmd_word), .o_code(cmd_code), .o_wdata(cmd_wdata));
  iprot_top iprot_top_i (.i_clock(i_clock), .i_srst(i_srst), .i_clock_en(clock_en), .i_cmd_valid(cmd_valid),
    .i_cmd_write(cmd_write), .i_cmd_word(cmd_word), .i_cmd_code(cmd_code), .i_cmd_wdata(cmd_wdata),
    .i_clear_faults(clear), .i_restore_defaults(restore), .i_nvm_turn_on(nvm_on),
    .i_nvm_overvolt_limit(nvm_ov), .i_nvm_undervolt_limit(nvm_uv), .i_nvm_input_current_limit(nvm_iin),
    .i_vin_quarter(vin), .i_unit_enable(unit_en), .i_alert_mask_overvolt(mask_ov),
    .i_alert_mask_undervolt(mask_uv), .o_cmd_ack(ack), .o_cmd_error(err), .o_cmd_rdata(rdata),
    .o_conversion_enable(conv), .o_status_byte_other(other), .o_status_word_input(in_word),
    .o_status_input_overvolt(ov), .o_status_input_undervolt(uv), .o_host_alert_pin_o(),
    .o_host_alert_pin_oe(alert_oe), .o_input_current_limit(iin_lim));
  always #2.5 i_clock = ~i_clock;
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic fail(input string msg);
    n_errors++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask
  task automatic cmp_ans(input logic [16:0] got, input logic [16:0] exp);
    tests_run++;
    if (got !== exp) fail($sformatf("answer %h expected %h", got, exp));
  endtask
  task automatic cmp_lvl(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) fail($sformatf("level %h expected %h", got, exp));
  endtask
  // kind: bit 1 write, bit 0 word; expectation is {error, read data}
  task automatic cmd(input logic [1:0] k, input logic [7:0] c, input logic [15:0] d, input logic [16:0] e);
    exp_q.push_back(e);
    iprot_host_model_i.xfer(k[1], k[0], c, d);
  endtask
  task automatic chk(input logic [5:0] e);
    cmp_lvl({10'h000, ov, uv, other, in_word, alert_oe, conv}, {10'h000, e});
  endtask
  task automatic set_vin(input logic [15:0] v);
    @(posedge i_clock);
    vin <= v;
    repeat (8) @(posedge i_clock);
    #1;
  endtask
  task automatic clear_pulse();
    @(posedge i_clock);
    clear <= 1'h1;
    @(posedge i_clock);
    clear <= 1'h0;
    repeat (3) @(posedge i_clock);
    #1;
  endtask
  task automatic conclude();
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_clock) begin
    if (ack === 1'h1) begin
      if (exp_q.size() == 0) fail("unexpected answer");
      else cmp_ans({err, rdata}, exp_q.pop_front());
    end
  end
  // whole run is under two hundred cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 5000) begin
      fail("timeout");
      conclude();
    end
  end
  initial begin
    {i_clock, clear, restore, unit_en, mask_ov, mask_uv, n_errors, tests_run, cycles} = '0;
    i_srst   = 1'h1;
    clock_en = 1'h1;
    nvm_on   = 16'hF021;
    nvm_ov   = 16'h000E;
    nvm_uv   = 16'hF80B;
    nvm_iin  = 16'hF835;
    vin      = 16'h0000;
    lfsr     = 8'h5A;
    repeat (3) @(posedge i_clock);
    i_srst <= 1'h0;
    #1;
    cmp_lvl(iin_lim, 16'hF87F);
    cmd(2'h1, 8'h35, 16'h0000, 17'h0F021);
    cmd(2'h1, 8'h55, 16'h0000, 17'h0000E);
    cmd(2'h1, 8'h59, 16'h0000, 17'h0F80B);
    cmd(2'h0, 8'h56, 16'h0000, 17'h00000);
    cmd(2'h0, 8'h5A, 16'h0000, 17'h000C0);
    cmd(2'h0, 8'h55, 16'h0000, 17'h10000);
    cmd(2'h1, 8'h56, 16'h0000, 17'h10000);
    cmd(2'h1, 8'h99, 16'h0000, 17'h10000);
    cmd(2'h3, 8'h55, 16'h0020, 17'h10000);
    cmd(2'h3, 8'h5B, 16'h0080, 17'h10000);
    cmd(2'h3, 8'h59, 16'hF80C, 17'h10000);
    cmd(2'h2, 8'h56, 16'h00AA, 17'h00000);
    cmd(2'h0, 8'h56, 16'h0000, 17'h00000);
    cmd(2'h3, 8'h35, 16'h0015, 17'h00000);
    cmd(2'h1, 8'h35, 16'h0000, 17'h0F015);
    cmd(2'h3, 8'h59, 16'hF011, 17'h00000);
    cmd(2'h1, 8'h59, 16'h0000, 17'h0F011);
    cmd(2'h1, 8'h55, 16'h0000, 17'h0000E);
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      cmd(2'h3, 8'h55, {5'h1F, 6'h00, lfsr[4:0]}, 17'h00000);
      cmd(2'h1, 8'h55, 16'h0000, {12'h000, lfsr[4:0]});
      cmd(2'h3, 8'h5B, {9'h000, lfsr[6:0]}, 17'h00000);
      cmd(2'h1, 8'h5B, 16'h0000, {6'h1F, 4'h0, lfsr[6:0]});
    end
    iprot_host_model_i.idle();
    @(posedge i_clock);
    nvm_iin <= 16'hF830;
    restore <= 1'h1;
    @(posedge i_clock);
    restore <= 1'h0;
    #1;
    cmp_lvl(iin_lim, 16'hF830);
    cmd(2'h1, 8'h55, 16'h0000, 17'h0000E);
    iprot_host_model_i.idle();
    @(posedge i_clock);
    unit_en <= 1'h1;
    set_vin(16'd20);
    chk(6'b000000);
    set_vin(16'd40);
    chk(6'b000001);
    set_vin(16'd60);
    chk(6'b101111);
    set_vin(16'd40);
    chk(6'b101111);
    clear_pulse();
    chk(6'b000001);
    set_vin(16'd10);
    chk(6'b011110);
    set_vin(16'd40);
    chk(6'b011111);
    @(posedge i_clock);
    mask_ov <= 1'h1;
    mask_uv <= 1'h1;
    clear_pulse();
    set_vin(16'd10);
    chk(6'b011100);
    // frozen clock enable: no restart while held low
    @(posedge i_clock);
    clock_en <= 1'h0;
    set_vin(16'd40);
    chk(6'b011100);
    @(posedge i_clock);
    clock_en <= 1'h1;
    set_vin(16'd40);
    chk(6'b011101);
    repeat (4) @(posedge i_clock);
    if (exp_q.size() != 0) fail("missing answer");
    conclude();
  end
endmodule
